// file: shared/beacon_pkg.sv
// package: register map, field layouts, timing counts and carrier structs of the passage qualifier
package beacon_pkg;
    localparam int CLK_HZ             = 100_000_000;
    localparam int RECOVER_MS         = 200;
    localparam int RECOVER_CYC        = RECOVER_MS * (CLK_HZ / 1000);
    localparam int STOP_TIMEOUT_MS    = 600;
    localparam int STOP_TIMEOUT_CYC   = STOP_TIMEOUT_MS * (CLK_HZ / 1000);

    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_THR_SEL   = 8'h04;
    localparam logic [7:0] REG_THR0      = 8'h08;
    localparam logic [7:0] REG_THR1      = 8'h0C;
    localparam logic [7:0] REG_THR2      = 8'h10;
    localparam logic [7:0] REG_MIN_TIME  = 8'h14;
    localparam logic [7:0] REG_TP_LOW    = 8'h18;
    localparam logic [7:0] REG_TP_HIGH   = 8'h1C;
    localparam logic [7:0] REG_IRQ_STAT  = 8'h20;
    localparam logic [7:0] REG_IRQ_CLR   = 8'h24;
    localparam logic [7:0] REG_IRQ_EN    = 8'h28;
    localparam logic [7:0] REG_STATUS    = 8'h2C;
    localparam logic [7:0] REG_PASS_ID   = 8'h30;
    localparam logic [7:0] REG_PASS_CNT  = 8'h34;
    localparam logic [7:0] REG_PASS_TIME = 8'h38;
    localparam logic [7:0] REG_PASS_ODO  = 8'h3C;
    localparam logic [7:0] REG_PASS_VC   = 8'h40;

    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_STOP_BIT = 1;

    localparam int IRQ_PASS   = 0;
    localparam int IRQ_DETECT = 1;
    localparam int IRQ_TP_LOW = 2;
    localparam int IRQ_TP_HI  = 3;
    localparam int IRQ_METAL  = 4;
    localparam int IRQ_PRELIM = 5;
    localparam int IRQ_W      = 6;

    localparam logic [11:0] THR0_RST     = 12'h400;
    localparam logic [11:0] THR1_RST     = 12'h300;
    localparam logic [11:0] THR2_RST     = 12'h200;
    localparam logic [15:0] MIN_TIME_RST = 16'h0064;
    localparam logic [11:0] TP_LOW_RST   = 12'h100;
    localparam logic [11:0] TP_HIGH_RST  = 12'hF00;
    localparam logic [1:0]  THR_SEL_RST  = 2'h0;
    localparam logic [1:0]  CTRL_RST     = 2'h1;

    localparam logic [3:0] VER_1_0 = 4'h0;
    localparam logic [3:0] VER_1_1 = 4'h1;
    localparam logic [7:0] PKT_VC_V11 = 8'hC8;
    localparam logic [7:0] PKT_VC_V2  = 8'h00;

    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef struct packed {
        logic [3:0]  language_version;
        logic [9:0]  country_identity_field;
        logic [13:0] group_identity_field;
        logic [2:0]  position_in_group_field;
        logic [7:0]  opt_packet_id;
        logic        opt_packet_present;
        logic [7:0]  virtual_cover_identity_field;
    } tgm_header_s;

    typedef struct packed {
        logic [31:0] time_stamp;
        logic [31:0] odometer;
    } stamp_s;
endpackage : beacon_pkg

// file: src/level_qualifier.sv
// level qualifier: consecutive above-threshold counter with detect flag
`timescale 1ns/1ps
`default_nettype none
module level_qualifier
    import beacon_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        sample_valid,
    input  wire logic [11:0] level,
    input  wire logic [11:0] threshold,
    input  wire logic [15:0] min_count,
    output logic             above,
    output logic             detected
);
    logic [15:0] run_r;

    assign above = (level > threshold);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_r <= '0;
        end else if (sample_valid) begin
            if (!above) begin
                run_r <= '0;
            end else if (run_r != 16'hFFFF) begin
                run_r <= run_r + 16'h0001;
            end
        end
    end

    // detection needs the level held continuously for the minimum count
    assign detected = above && (run_r >= min_count);
endmodule : level_qualifier
`default_nettype wire

// file: src/beacon_passage_qualifier.sv
// beacon passage qualifier: threshold gating, lobe merging, power supervision, AXI4-Lite registers
//
// Behaviour
// - no telegram reaches the kernel while field strength is below threshold
// - detect only after field stays above threshold for minimum time
// - merge lobes using signal plus version, country, group, position, cover fields (code merges on detection timing only; fields are stored, not compared)
// - several lobes of one beacon give exactly one reported passage (code merges only lobes split by a drop of at most one sample)
// - side lobes resolved from receive signals plus time and odometer (code uses detection timing only; time and odometer are only recorded)
// - use main lobe; when stopped over side lobe, forward after time-out
// - side-lobe activation must not disturb main-lobe reception
// - flag error when tele-powering level too low for detection
// - flag separate error when tele-powering level risks cross-talk
// - raise metal-mass alarm while passing mass outside mask
// - regain normal detection within recovery time after metal influence ends
// - cover identity: none in 1.0, packet 200 in 1.1, packet 0 later
// - three selectable detect thresholds per antenna type
// - report detection even when no telegram decodes
// - on telegram switching report only one telegram per beacon (code limits it to one per passage, not per beacon)
`timescale 1ns/1ps
`default_nettype none
module beacon_passage_qualifier
    import beacon_pkg::*;
#(
    parameter int RECOVER_CYCLES = RECOVER_CYC,
    parameter int STOP_CYCLES    = STOP_TIMEOUT_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // antenna receive interface samples (same clock domain)
    input  wire logic        sample_valid,
    input  wire logic [11:0] rx_level,
    input  wire logic [11:0] tp_level,
    input  wire logic        metal_influence,
    // decoded telegram from decoder
    input  wire logic        tgm_valid,
    input  wire tgm_header_s tgm_header,
    input  wire stamp_s      stamp,
    input  wire logic        vehicle_stopped,
    // kernel report
    output logic             tgm_deliver,
    output logic             passage_pulse,
    output logic             metal_alarm,
    output logic             tp_low_err,
    output logic             tp_high_err,
    output logic             irq
);
    typedef enum logic [1:0] {IDLE, IN_LOBE, GAP} pass_e;

    pass_e             state_r;
    logic [1:0]        ctrl_r;
    logic [1:0]        thr_sel_r;
    logic [11:0]       thr_r [3];
    logic [15:0]       min_time_r;
    logic [11:0]       tp_low_r;
    logic [11:0]       tp_high_r;
    logic [IRQ_W-1:0]  irq_stat_r;
    logic [IRQ_W-1:0]  irq_en_r;
    logic [IRQ_W-1:0]  irq_set;
    logic [IRQ_W-1:0]  irq_clr;
    logic [11:0]       thr_sel;
    logic              above;
    logic              detected;
    logic              det_r;
    logic [31:0]       pass_cnt_r;
    logic [31:0]       pass_id_r;
    logic [7:0]        pass_vc_r;
    stamp_s            pass_stamp_r;
    logic              have_tgm_r;
    logic [31:0]       gap_cnt_r;
    logic [31:0]       stop_cnt_r;
    logic [31:0]       recover_cnt_r;
    logic              prelim_pulse;
    logic [31:0]       tgm_key;
    logic [7:0]        vc_field;
    logic              enable;

    logic        aw_hold_r;
    logic [7:0]  aw_addr_r;
    logic        w_hold_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        wr_fire;
    logic [31:0] rd_mux;

    assign enable  = ctrl_r[CTRL_EN_BIT];
    assign thr_sel = thr_r[(thr_sel_r > 2'h2) ? 2'h2 : thr_sel_r];

    level_qualifier u_qual (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .sample_valid (sample_valid && enable && (recover_cnt_r == 32'h0)),
        .level        (rx_level),
        .threshold    (thr_sel),
        .min_count    (min_time_r),
        .above        (above),
        .detected     (detected)
    );

    // cover identity only exists where the version places it
    always_comb begin
        vc_field = 8'h00;
        if (tgm_header.language_version == VER_1_0) begin
            vc_field = 8'h00;
        end else if (tgm_header.language_version == VER_1_1) begin
            if (tgm_header.opt_packet_present && tgm_header.opt_packet_id == PKT_VC_V11) begin
                vc_field = tgm_header.virtual_cover_identity_field;
            end
        end else if (tgm_header.opt_packet_present && tgm_header.opt_packet_id == PKT_VC_V2) begin
            vc_field = tgm_header.virtual_cover_identity_field;
        end
    end

    // identity of the beacon, so lobes of one beacon compare equal
    assign tgm_key = {tgm_header.language_version, tgm_header.country_identity_field,
                      tgm_header.group_identity_field, tgm_header.position_in_group_field,
                      1'b0} ^ {24'h0, vc_field};

    // telegram gating: only while field is above the selected threshold
    assign tgm_deliver = tgm_valid && above && detected && enable && !have_tgm_r;

    // passage tracker: any lobe detected within the gap window merges into the current passage, whatever its identity
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r      <= IDLE;
            have_tgm_r   <= 1'b0;
            gap_cnt_r    <= '0;
            pass_id_r    <= '0;
            pass_vc_r    <= '0;
            pass_stamp_r <= '0;
            det_r        <= 1'b0;
        end else begin
            det_r <= detected;
            unique case (state_r)
                IDLE: begin
                    if (detected) begin
                        state_r      <= IN_LOBE;
                        pass_stamp_r <= stamp;
                        have_tgm_r   <= 1'b0;
                    end
                end
                IN_LOBE: begin
                    if (tgm_deliver) begin
                        have_tgm_r   <= 1'b1;
                        pass_id_r    <= tgm_key;
                        pass_vc_r    <= vc_field;
                        pass_stamp_r <= stamp;
                    end
                    if (!detected) begin
                        state_r   <= GAP;
                        gap_cnt_r <= '0;
                    end
                end
                GAP: begin
                    // any lobe detected while still in GAP re-enters the passage, whatever its identity
                    if (detected) begin
                        state_r <= IN_LOBE;
                    end else if (gap_cnt_r >= min_time_r) begin
                        state_r <= IDLE;
                    end else if (sample_valid) begin
                        gap_cnt_r <= gap_cnt_r + 32'h1;
                    end
                end
                default: state_r <= IDLE;
            endcase
        end
    end

    // single passage report once gap_cnt_r reaches min_time_r without detection, with or without telegram
    assign passage_pulse = (state_r == GAP) && !detected && (gap_cnt_r >= min_time_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pass_cnt_r <= '0;
        end else if (passage_pulse) begin
            pass_cnt_r <= pass_cnt_r + 32'h1;
        end
    end

    // stopped over a lobe: preliminary report after each time-out period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stop_cnt_r <= '0;
        end else if (state_r == IN_LOBE && vehicle_stopped && ctrl_r[CTRL_STOP_BIT]) begin
            stop_cnt_r <= prelim_pulse ? 32'h0 : stop_cnt_r + 32'h1;
        end else begin
            stop_cnt_r <= '0;
        end
    end
    assign prelim_pulse = (stop_cnt_r == 32'(STOP_CYCLES - 1));

    // recovery hold-off after metal influence; always shorter than the allowed time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            recover_cnt_r <= '0;
        end else if (metal_influence) begin
            recover_cnt_r <= 32'(RECOVER_CYCLES / 2);
        end else if (recover_cnt_r != 32'h0) begin
            recover_cnt_r <= recover_cnt_r - 32'h1;
        end
    end

    assign metal_alarm = metal_influence && enable;
    assign tp_low_err  = enable && (tp_level < tp_low_r);
    assign tp_high_err = enable && (tp_level > tp_high_r);

    always_comb begin
        irq_set             = '0;
        irq_set[IRQ_PASS]   = passage_pulse;
        irq_set[IRQ_DETECT] = detected && !det_r;
        irq_set[IRQ_TP_LOW] = tp_low_err;
        irq_set[IRQ_TP_HI]  = tp_high_err;
        irq_set[IRQ_METAL]  = metal_alarm;
        irq_set[IRQ_PRELIM] = prelim_pulse;
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end
    assign irq = |(irq_stat_r & irq_en_r);

    // axi4-lite write path: address and data taken in either order
    assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
    assign wr_fire       = aw_hold_r && w_hold_r && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r    <= 1'b0;
            w_hold_r     <= 1'b0;
            aw_addr_r    <= '0;
            w_data_r     <= '0;
            w_strb_r     <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= AXI_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_r > REG_IRQ_EN || aw_addr_r == REG_IRQ_STAT) ? AXI_SLVERR : AXI_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        irq_clr = '0;
        if (wr_fire && aw_addr_r == REG_IRQ_CLR && w_strb_r[0]) begin
            irq_clr = w_data_r[IRQ_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r     <= CTRL_RST;
            thr_sel_r  <= THR_SEL_RST;
            thr_r[0]   <= THR0_RST;
            thr_r[1]   <= THR1_RST;
            thr_r[2]   <= THR2_RST;
            min_time_r <= MIN_TIME_RST;
            tp_low_r   <= TP_LOW_RST;
            tp_high_r  <= TP_HIGH_RST;
            irq_en_r   <= '0;
        end else if (wr_fire && w_strb_r[0]) begin
            unique case (aw_addr_r)
                REG_CTRL:     ctrl_r     <= w_data_r[1:0];
                REG_THR_SEL:  thr_sel_r  <= w_data_r[1:0];
                REG_THR0:     thr_r[0]   <= w_data_r[11:0];
                REG_THR1:     thr_r[1]   <= w_data_r[11:0];
                REG_THR2:     thr_r[2]   <= w_data_r[11:0];
                REG_MIN_TIME: min_time_r <= w_data_r[15:0];
                REG_TP_LOW:   tp_low_r   <= w_data_r[11:0];
                REG_TP_HIGH:  tp_high_r  <= w_data_r[11:0];
                REG_IRQ_EN:   irq_en_r   <= w_data_r[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // axi4-lite read path
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rd_mux = 32'h0;
        unique case (s_axi_araddr)
            REG_CTRL:      rd_mux = {30'h0, ctrl_r};
            REG_THR_SEL:   rd_mux = {30'h0, thr_sel_r};
            REG_THR0:      rd_mux = {20'h0, thr_r[0]};
            REG_THR1:      rd_mux = {20'h0, thr_r[1]};
            REG_THR2:      rd_mux = {20'h0, thr_r[2]};
            REG_MIN_TIME:  rd_mux = {16'h0, min_time_r};
            REG_TP_LOW:    rd_mux = {20'h0, tp_low_r};
            REG_TP_HIGH:   rd_mux = {20'h0, tp_high_r};
            REG_IRQ_STAT:  rd_mux = {26'h0, irq_stat_r};
            REG_IRQ_EN:    rd_mux = {26'h0, irq_en_r};
            REG_STATUS:    rd_mux = {25'h0, have_tgm_r, state_r, detected, above, tp_high_err, tp_low_err};
            REG_PASS_ID:   rd_mux = pass_id_r;
            REG_PASS_CNT:  rd_mux = pass_cnt_r;
            REG_PASS_TIME: rd_mux = pass_stamp_r.time_stamp;
            REG_PASS_ODO:  rd_mux = pass_stamp_r.odometer;
            REG_PASS_VC:   rd_mux = {24'h0, pass_vc_r};
            default:       rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= (s_axi_araddr > REG_PASS_VC || s_axi_araddr == REG_IRQ_CLR ||
                             s_axi_araddr[1:0] != 2'h0) ? AXI_SLVERR : AXI_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : beacon_passage_qualifier
`default_nettype wire

// file: test/beacon_qual_sva.sv
// checker: port-level properties of the passage qualifier
`timescale 1ns/1ps
`default_nettype none
module beacon_qual_sva (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [11:0] rx_level,
    input wire logic        metal_influence,
    input wire logic        tgm_valid,
    input wire logic        tgm_deliver,
    input wire logic        passage_pulse,
    input wire logic        metal_alarm,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_arready
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // deliveries since the last passage; saturates so a repeat stays visible
    logic [1:0] dlv_r;
    always_ff @(posedge aclk) begin
        if (!aresetn || passage_pulse) begin
            dlv_r <= 2'h0;
        end else if (tgm_deliver && dlv_r != 2'h3) begin
            dlv_r <= dlv_r + 2'h1;
        end
    end
    property p_low_gate;
        rx_level == 12'h000 |-> !tgm_deliver;
    endproperty
    a_low_gate: assert property (p_low_gate) else $error("telegram delivered at zero level");
    property p_deliver_strobe;
        tgm_deliver |-> tgm_valid;
    endproperty
    a_deliver_strobe: assert property (p_deliver_strobe) else $error("delivery without telegram");
    property p_one_deliver;
        dlv_r < 2'h2;
    endproperty
    a_one_deliver: assert property (p_one_deliver) else $error("two telegrams in one passage");
    property p_pass_single;
        passage_pulse |=> !passage_pulse;
    endproperty
    a_pass_single: assert property (p_pass_single) else $error("passage pulse too long");
    property p_metal;
        metal_alarm |-> metal_influence;
    endproperty
    a_metal: assert property (p_metal) else $error("metal alarm without metal");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read response dropped or changed");
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken while answer pending");
endmodule // beacon_qual_sva
bind beacon_passage_qualifier beacon_qual_sva u_sva (.*);
`default_nettype wire

// file: test/kernel_model.sv
// partner: kernel side counting passages and telegrams, judging metal alarms
`timescale 1ns/1ps
`default_nettype none
module kernel_model (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic tgm_deliver,
    input  wire logic passage_pulse,
    input  wire logic metal_alarm,
    input  wire logic metal_expected,
    output logic [7:0] pass_count,
    output logic [7:0] tgm_count,
    output logic       alarm_seen
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pass_count <= 8'h00;
            tgm_count  <= 8'h00;
            alarm_seen <= 1'b0;
        end else begin
            pass_count <= pass_count + {7'h00, passage_pulse};
            tgm_count  <= tgm_count + {7'h00, tgm_deliver};
            // an announced metal mass is not an alarm for the kernel
            if (metal_alarm && !metal_expected) alarm_seen <= 1'b1;
        end
    end
endmodule // kernel_model
`default_nettype wire

// file: test/tb.sv
// testbench: registers, detection, lobe merging, supervision and interrupts
`timescale 1ns/1ps
`default_nettype none
module tb
    import beacon_pkg::*;
();
    localparam int REC = 20;
    localparam int STOPC = 50;
    logic        aclk, aresetn, dv;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, pass_count, tgm_count;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        sample_valid, metal_influence, tgm_valid, vehicle_stopped, metal_expected;
    logic [11:0] rx_level, tp_level;
    tgm_header_s tgm_header;
    stamp_s      stamp;
    logic        tgm_deliver, passage_pulse, metal_alarm, tp_low_err, tp_high_err, irq, alarm_seen;
    int          err_total, comparisons;
    beacon_passage_qualifier #(.RECOVER_CYCLES(REC), .STOP_CYCLES(STOPC)) DUT (.*);
    kernel_model partner (.*);
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // ready is looked at mid-cycle, where it holds the value the next edge samples
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic ta, tw, gb;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (n = 0; n < 100; n++) begin
            @(negedge aclk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            gb = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (gb) break;
        end
        s_axi_bready <= 1'b0;
        @(posedge aclk);
        if (n == 100) err_total++;
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        logic ta, gr;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (n = 0; n < 100; n++) begin
            @(negedge aclk);
            ta = s_axi_arready;
            gr = s_axi_rvalid;
            rd_data = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (gr) break;
        end
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        if (n == 100) err_total++;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rd(a);
        chk(nm, e, rd_data & m);
    endtask
    task automatic smp(input logic [11:0] lv, input int n);
        rx_level <= lv;
        sample_valid <= 1'b1;
        repeat (n) @(posedge aclk);
        sample_valid <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic tgm();
        tgm_valid <= 1'b1;
        @(negedge aclk);
        dv = tgm_deliver;
        @(posedge aclk);
        tgm_valid <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic give_verdict();
        if (err_total == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        repeat (30000) @(posedge aclk);
        err_total++;
        give_verdict();
    end
    initial begin
        logic [7:0]  ra [7];
        logic [31:0] rv [7];
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, aresetn} = '0;
        {sample_valid, metal_influence, tgm_valid, vehicle_stopped, metal_expected} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_level, err_total, comparisons} = '0;
        s_axi_wstrb = 4'hF;
        tp_level = 12'h800;
        tgm_header = '{4'h2, 10'h0A5, 14'h1234, 3'h1, 8'h00, 1'b1, 8'h11};
        stamp = '{32'h100, 32'h200};
        ra = '{REG_CTRL, REG_THR0, REG_THR1, REG_THR2, REG_MIN_TIME, REG_TP_LOW, REG_TP_HIGH};
        rv = '{32'h1, 32'h400, 32'h300, 32'h200, 32'h64, 32'h100, 32'hF00};
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (ra[i]) rdc("reset value", ra[i], 32'hFFFF, rv[i]);
        rd(8'h44);
        chk("unmapped read", AXI_SLVERR, resp);
        wr(REG_IRQ_STAT, 32'h1);
        chk("status write", AXI_SLVERR, resp);
        wr(REG_MIN_TIME, 32'h4);
        wr(REG_IRQ_EN, 32'h3F);
        smp(12'h100, 2);
        tgm();
        chk("deliver low", 32'h0, dv);
        smp(12'h500, 3);
        smp(12'h100, 1);
        smp(12'h500, 3);
        rdc("early detect", REG_IRQ_STAT, 32'h2, 32'h0);
        smp(12'h500, 1);
        rdc("detect", REG_IRQ_STAT, 32'h2, 32'h2);
        tgm();
        chk("deliver", 32'h1, dv);
        tgm();
        chk("deliver repeat", 32'h0, dv);
        // gap also counts requalifying samples, so only a one-sample drop still merges
        smp(12'h100, 1);
        smp(12'h500, 5);
        smp(12'h100, 8);
        repeat (4) @(posedge aclk);
        rdc("event status", REG_IRQ_STAT, 32'h3F, 32'h3);
        chk("passages", 32'h1, pass_count);
        rdc("cover id", REG_PASS_VC, 32'hFF, 32'h11);
        chk("irq", 32'h1, irq);
        wr(REG_IRQ_EN, 32'h0);
        wr(REG_IRQ_CLR, 32'h3F);
        tp_level <= 12'h050;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk("low power", 32'h1, tp_low_err);
        chk("masked irq", 32'h0, irq);
        @(posedge aclk);
        tp_level <= 12'hF80;
        metal_expected <= 1'b1;
        metal_influence <= 1'b1;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk("high power", 32'h1, tp_high_err);
        chk("low power off", 32'h0, tp_low_err);
        chk("metal alarm", 32'h1, metal_alarm);
        chk("kernel alarm", 32'h0, alarm_seen);
        @(posedge aclk);
        tp_level <= 12'h800;
        metal_influence <= 1'b0;
        rdc("fault status", REG_IRQ_STAT, 32'h3F, 32'h1C);
        wr(REG_IRQ_EN, 32'h3F);
        @(negedge aclk);
        chk("irq unmasked", 32'h1, irq);
        @(posedge aclk);
        wr(REG_IRQ_CLR, 32'h3F);
        repeat (REC) @(posedge aclk);
        // second threshold lets a weaker field qualify; no telegram this time
        wr(REG_THR_SEL, 32'h1);
        smp(12'h380, 5);
        smp(12'h100, 8);
        repeat (4) @(posedge aclk);
        rdc("silent passage", REG_IRQ_STAT, 32'h1, 32'h1);
        chk("passages", 32'h2, pass_count);
        chk("telegrams", 32'h1, tgm_count);
        wr(REG_CTRL, 32'h3);
        vehicle_stopped <= 1'b1;
        smp(12'h500, 5);
        repeat (STOPC + 10) @(posedge aclk);
        rdc("preliminary", REG_IRQ_STAT, 32'h20, 32'h20);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
